// ==== src/bcpi_ctrl.sv ====
// battery charger controller: supervisor, pi law and pwm drive
`timescale 1ns/1ps
`default_nettype none

// Contract
// - keep switching frequency fixed, regulate only by pulse width
// - constant voltage: error from converter voltage against voltage setpoint
// - constant current: error from sense voltage against current setpoint
// - loop holds voltage or current, whichever mode is selected
// - proportional term uses measured value compared with set value
// - integral term is a running sum of error samples
// - position form: c1 times error plus c2 times past error sum
// - velocity form: add gain times error plus gain times last error
// - lithium and lead acid cells charge by the constant voltage method
// - constant voltage charging cuts drive while current exceeds limit
// - fast charge uses current setpoint equal to rated capacity
// - monitor always, end charge when battery voltage hits threshold
// - any safety threshold crossed switches pwm off and stops charging
// - a new duty cycle is computed once every 5 ms
module bcpi_ctrl #(
	parameter int unsigned TICK_CYCLES = bcpi_pkg::TICK_CYCLES,
	parameter int unsigned PWM_PERIOD  = bcpi_pkg::PWM_PERIOD,
	parameter int unsigned MEAS_W      = bcpi_pkg::MEAS_W
) (
	input  wire logic                              mclk,
	input  wire logic                              rst,
	input  wire logic                              charge_enable,
	input  wire logic                              mode_cc,
	input  wire logic                              velocity_form,
	input  wire logic                              fast_charge,
	input  wire logic                              temp_sense_present,
	input  wire logic [MEAS_W-1:0]                 voltage_setpoint,
	input  wire logic [MEAS_W-1:0]                 current_setpoint,
	input  wire logic [MEAS_W-1:0]                 rated_capacity,
	input  wire logic [MEAS_W-1:0]                 current_limit,
	input  wire logic [MEAS_W-1:0]                 term_voltage,
	input  wire logic [MEAS_W-1:0]                 vout_limit,
	input  wire logic [MEAS_W-1:0]                 vbatt_limit,
	input  wire logic [MEAS_W-1:0]                 temp_limit,
	input  wire logic signed [bcpi_pkg::GAIN_W-1:0] proportional_gain,
	input  wire logic signed [bcpi_pkg::GAIN_W-1:0] integral_gain,
	input  wire logic [MEAS_W-1:0]                 vout_meas,
	input  wire logic [MEAS_W-1:0]                 isense_meas,
	input  wire logic [MEAS_W-1:0]                 vbatt_meas,
	input  wire logic [MEAS_W-1:0]                 temp_meas,
	output wire logic                              pwm_out,
	output wire logic [bcpi_pkg::DUTY_W-1:0]       duty,
	output wire logic                              charging,
	output wire logic                              charge_done,
	output wire logic                              safety_fault,
	output wire logic                              current_limited
);

	localparam int unsigned ACC_W = bcpi_pkg::ACC_W;
	localparam int unsigned SUM_W = bcpi_pkg::SUM_W;
	localparam int unsigned DW    = bcpi_pkg::DUTY_W;
	localparam int unsigned EW    = MEAS_W + 1;
	localparam int unsigned SW1   = SUM_W + 1;

	localparam logic signed [ACC_W-1:0] DUTY_MAX = ACC_W'(PWM_PERIOD);
	localparam logic signed [SW1-1:0]   SUM_MAX  =
		SW1'({2'h0, {(SUM_W-1){1'b1}}});
	localparam logic signed [SW1-1:0]   SUM_MIN  =
		SW1'({2'h3, {(SUM_W-1){1'b0}}});

	// clamp a signed result into the legal compare range
	function automatic logic [DW-1:0] sat_duty(
		input logic signed [ACC_W-1:0] v
	);
		if (v < 0) begin
			sat_duty = '0;
		end else if (v > DUTY_MAX) begin
			sat_duty = DUTY_MAX[DW-1:0];
		end else begin
			sat_duty = v[DW-1:0];
		end
	endfunction

	// clamp the widened accumulator sum instead of letting it wrap
	function automatic logic signed [SUM_W-1:0] sat_sum(
		input logic signed [SW1-1:0] v
	);
		if (v > SUM_MAX) begin
			sat_sum = SUM_MAX[SUM_W-1:0];
		end else if (v < SUM_MIN) begin
			sat_sum = SUM_MIN[SUM_W-1:0];
		end else begin
			sat_sum = v[SUM_W-1:0];
		end
	endfunction

	bcpi_pkg::bcpi_state_t state_q;
	bcpi_pkg::bcpi_state_t state_d;

	logic                    lim_q;
	logic                    charging_q;
	logic                    done_q;
	logic                    fault_q;
	logic [DW-1:0]           duty_q;
	logic signed [SUM_W-1:0] sum_q;
	logic signed [EW-1:0]    err_prev_q;
	logic                    tick_q;

	// safety and termination checks run every cycle, not only on ticks
	wire temp_trip   = temp_sense_present && (temp_meas > temp_limit);
	wire safety_trip = (vout_meas > vout_limit) ||
		(vbatt_meas > vbatt_limit) || temp_trip;
	wire term_hit    = (vbatt_meas >= term_voltage);
	wire in_charge   = (state_q == bcpi_pkg::ST_CHARGE);

	wire lim_d    = in_charge && !mode_cc && (isense_meas > current_limit);
	// drive only while charging and not limited
	wire drive_en = in_charge && !lim_q;

	// fast charge targets the rated capacity
	wire [MEAS_W-1:0] cur_target = fast_charge ? rated_capacity
		: current_setpoint;

	// mode_cc low is the constant voltage method, the default
	// selected mode picks the regulated quantity
	wire [MEAS_W-1:0] target = mode_cc ? cur_target : voltage_setpoint;
	wire [MEAS_W-1:0] meas   = mode_cc ? isense_meas : vout_meas;

	// error is set value minus measured value
	wire signed [EW-1:0] err = $signed({1'b0, target}) -
		$signed({1'b0, meas});

	// law advances only on the update tick
	// freezing during a current cut keeps the integrator from winding up
	wire pi_step = tick_q && drive_en;

	wire signed [ACC_W-1:0] p_term = ACC_W'(proportional_gain) *
		ACC_W'(err);
	wire signed [ACC_W-1:0] i_src  = velocity_form ? ACC_W'(err_prev_q)
		: ACC_W'(sum_q);
	wire signed [ACC_W-1:0] i_term = ACC_W'(integral_gain) * i_src;
	wire signed [ACC_W-1:0] mix    = (p_term + i_term) >>>
		bcpi_pkg::GAIN_SHIFT;

	// velocity form adds the change to the previous output
	wire signed [ACC_W-1:0] vel_u  = ACC_W'($signed({1'b0, duty_q})) + mix;
	wire signed [ACC_W-1:0] u_raw  = velocity_form ? vel_u : mix;

	wire [DW-1:0]           duty_d = sat_duty(u_raw);
	wire signed [SUM_W-1:0] sum_d  = sat_sum(SW1'(sum_q) + SW1'(err));

	// supervisor; a fault outranks termination in the same cycle
	always_comb begin
		state_d = state_q;
		unique case (state_q)
			bcpi_pkg::ST_IDLE: begin
				if (charge_enable) begin
					state_d = safety_trip ? bcpi_pkg::ST_FAULT
						: bcpi_pkg::ST_CHARGE;
				end
			end
			bcpi_pkg::ST_CHARGE: begin
				if (!charge_enable) begin
					state_d = bcpi_pkg::ST_IDLE;
				end else if (safety_trip) begin
					state_d = bcpi_pkg::ST_FAULT;
				end else if (term_hit) begin
					state_d = bcpi_pkg::ST_DONE;
				end
			end
			bcpi_pkg::ST_DONE, bcpi_pkg::ST_FAULT: begin
				if (!charge_enable) begin
					state_d = bcpi_pkg::ST_IDLE;
				end
			end
		endcase
	end

	// state and registered status outputs
	always_ff @(posedge mclk) begin
		if (rst) begin
			state_q    <= bcpi_pkg::ST_IDLE;
			lim_q      <= 1'b0;
			charging_q <= 1'b0;
			done_q     <= 1'b0;
			fault_q    <= 1'b0;
		end else begin
			state_q    <= state_d;
			lim_q      <= lim_d;
			charging_q <= (state_d == bcpi_pkg::ST_CHARGE);
			done_q     <= (state_d == bcpi_pkg::ST_DONE);
			fault_q    <= (state_d == bcpi_pkg::ST_FAULT);
		end
	end

	// pi state, cleared when idle for a fresh start
	always_ff @(posedge mclk) begin
		if (rst || state_q == bcpi_pkg::ST_IDLE) begin
			duty_q     <= bcpi_pkg::DUTY_RST;
			sum_q      <= bcpi_pkg::SUM_RST;
			err_prev_q <= '0;
		end else if (pi_step) begin
			duty_q     <= duty_d;
			sum_q      <= sum_d;
			err_prev_q <= err;
		end
	end

	bcpi_tick #(
		.CYCLES (TICK_CYCLES)
	) u_tick (
		.mclk   (mclk),
		.rst    (rst),
		.tick_q (tick_q)
	);

	bcpi_pwm #(
		.PERIOD (PWM_PERIOD),
		.DW     (DW)
	) u_pwm (
		.mclk   (mclk),
		.rst    (rst),
		.enable (drive_en),
		.duty   (duty_q),
		.pwm_q  (pwm_out)
	);

	assign duty            = duty_q;
	assign charging        = charging_q;
	assign charge_done     = done_q;
	assign safety_fault    = fault_q;
	assign current_limited = lim_q;

	a_fault_off: assert property (@(posedge mclk) disable iff (rst)
		(in_charge && safety_trip) |-> ##2 !pwm_out [*2])
		else $error("pwm still on after safety trip");

	a_term_done: assert property (@(posedge mclk) disable iff (rst)
		(in_charge && charge_enable && !safety_trip && term_hit)
		|=> (state_q == bcpi_pkg::ST_DONE) && done_q && !charging_q)
		else $error("charge not ended at threshold");

	a_limit_cut: assert property (@(posedge mclk) disable iff (rst)
		(in_charge && !mode_cc && isense_meas > current_limit)
		|-> ##1 lim_q ##1 !pwm_out)
		else $error("current limit did not cut drive");

	a_duty_range: assert property (@(posedge mclk) disable iff (rst)
		duty_q <= DUTY_MAX[DW-1:0])
		else $error("duty above period");

	a_sum_run: assert property (@(posedge mclk) disable iff (rst)
		(pi_step && !$past(rst)) |=> sum_q ==
		sat_sum(SW1'($past(sum_q)) + SW1'($past(err))))
		else $error("error sum not accumulated");

	a_pos_law: assert property (@(posedge mclk) disable iff (rst)
		(pi_step && !velocity_form) |=> duty_q == sat_duty($past(mix)))
		else $error("position law mismatch");

	a_vel_up: assert property (@(posedge mclk) disable iff (rst)
		(pi_step && velocity_form && proportional_gain > 0 &&
		integral_gain >= 0 && err > 0 && err_prev_q >= 0)
		|=> duty_q >= $past(duty_q))
		else $error("velocity step went the wrong way");

	a_cv_sign: assert property (@(posedge mclk) disable iff (rst)
		(pi_step && !mode_cc && !velocity_form && sum_q <= 0 &&
		vout_meas > voltage_setpoint && proportional_gain > 0 &&
		integral_gain >= 0) |=> duty_q == '0)
		else $error("voltage error not from converter voltage");

	a_cc_sign: assert property (@(posedge mclk) disable iff (rst)
		(pi_step && mode_cc && !velocity_form && sum_q <= 0 &&
		isense_meas > cur_target && proportional_gain > 0 &&
		integral_gain >= 0) |=> duty_q == '0)
		else $error("current error not from sense voltage");

	a_hold_duty: assert property (@(posedge mclk) disable iff (rst)
		(!pi_step && state_q != bcpi_pkg::ST_IDLE) |=> $stable(duty_q))
		else $error("duty moved between ticks");

	// a cut must freeze the law, else the integrator winds up
	a_pi_frozen: assert property (@(posedge mclk) disable iff (rst)
		(tick_q && lim_q && in_charge)
		|=> $stable(duty_q) && $stable(sum_q))
		else $error("pi state moved during current cut");

	a_lim_free: assert property (@(posedge mclk) disable iff (rst)
		(!in_charge || mode_cc) |=> !lim_q)
		else $error("limiter active outside voltage charge");

	a_fault_hold: assert property (@(posedge mclk) disable iff (rst)
		(state_q == bcpi_pkg::ST_FAULT && charge_enable)
		|=> (state_q == bcpi_pkg::ST_FAULT) && fault_q && !pwm_out)
		else $error("fault released while charge requested");

	a_done_off: assert property (@(posedge mclk) disable iff (rst)
		(state_q == bcpi_pkg::ST_DONE) |=> !pwm_out && !charging_q)
		else $error("drive still on after termination");

	a_idle_clear: assert property (@(posedge mclk) disable iff (rst)
		(state_q == bcpi_pkg::ST_IDLE)
		|=> duty_q == '0 && sum_q == '0 && err_prev_q == '0)
		else $error("pi state not cleared in idle");

endmodule // bcpi_ctrl

`default_nettype wire

// ==== src/bcpi_pkg.sv ====
// shared constants and types of the battery charge pi pwm controller
package bcpi_pkg;

	// clock rate and control update period
	localparam int unsigned CLK_MHZ        = 25;
	localparam int unsigned CTRL_PERIOD_US = 5000;
	localparam int unsigned TICK_CYCLES    = CTRL_PERIOD_US * CLK_MHZ;

	// switching period in clock cycles, 100 kHz at 25 MHz
	localparam int unsigned PWM_PERIOD = 250;

	// datapath widths
	localparam int unsigned MEAS_W = 12;
	localparam int unsigned GAIN_W = 8;
	localparam int unsigned DUTY_W = 16;
	localparam int unsigned SUM_W  = 20;
	localparam int unsigned ACC_W  = 32;

	// gains are fixed point with this many fraction bits
	localparam int unsigned GAIN_SHIFT = 4;

	// reset values
	localparam logic [15:0] DUTY_RST = 16'h0000;
	localparam logic [19:0] SUM_RST  = 20'h00000;

	// supervisor states, gray coded along idle, charge, done
	typedef enum logic [1:0] {
		ST_IDLE   = 2'h0,
		ST_CHARGE = 2'h1,
		ST_DONE   = 2'h3,
		ST_FAULT  = 2'h2
	} bcpi_state_t;

endpackage

// ==== src/bcpi_tick.sv ====
// control update tick generator
`timescale 1ns/1ps
`default_nettype none

module bcpi_tick #(
	parameter int unsigned CYCLES = bcpi_pkg::TICK_CYCLES
) (
	input  wire logic mclk,
	input  wire logic rst,
	output var  logic tick_q
);

	localparam int unsigned  CW   = $clog2(CYCLES);
	localparam logic [CW-1:0] LAST = CW'(CYCLES - 1);

	logic [CW-1:0] cnt_q;
	wire           wrap = (cnt_q == LAST);

	// free running divider, one pulse per update period
	always_ff @(posedge mclk) begin
		if (rst) begin
			cnt_q  <= '0;
			tick_q <= 1'b0;
		end else begin
			cnt_q  <= wrap ? '0 : cnt_q + 1'b1;
			tick_q <= wrap;
		end
	end

	a_tick_lone: assert property (@(posedge mclk) disable iff (rst)
		tick_q |=> !tick_q) else $error("tick longer than one cycle");

	a_tick_wrap: assert property (@(posedge mclk) disable iff (rst)
		wrap |=> (tick_q && cnt_q == '0)) else $error("tick missed wrap");

endmodule // bcpi_tick

`default_nettype wire

// ==== src/bcpi_pwm.sv ====
// fixed frequency pwm generator with shadowed compare value
`timescale 1ns/1ps
`default_nettype none

module bcpi_pwm #(
	parameter int unsigned PERIOD = bcpi_pkg::PWM_PERIOD,
	parameter int unsigned DW     = bcpi_pkg::DUTY_W
) (
	input  wire logic          mclk,
	input  wire logic          rst,
	input  wire logic          enable,
	input  wire logic [DW-1:0] duty,
	output var  logic          pwm_q
);

	localparam logic [DW-1:0] LAST = DW'(PERIOD - 1);

	logic [DW-1:0] cnt_q;
	logic [DW-1:0] shadow_q;
	wire           wrap = (cnt_q == LAST);

	// fixed period, width only
	// compare loads at wrap so a duty change never splits a pulse mid period; enable still cuts one at once
	always_ff @(posedge mclk) begin
		if (rst) begin
			cnt_q    <= '0;
			shadow_q <= bcpi_pkg::DUTY_RST;
			pwm_q    <= 1'b0;
		end else begin
			cnt_q    <= wrap ? '0 : cnt_q + 1'b1;
			shadow_q <= wrap ? duty : shadow_q;
			pwm_q    <= enable && (cnt_q < shadow_q);
		end
	end

	a_pwm_period: assert property (@(posedge mclk) disable iff (rst)
		wrap |=> cnt_q == '0) else $error("pwm period broken");

	a_pwm_shadow: assert property (@(posedge mclk) disable iff (rst)
		!$stable(shadow_q) |-> $past(wrap)) else $error("compare moved");

endmodule // bcpi_pwm

`default_nettype wire

// ==== sim/bcpi_buck_model.sv ====
// behavioural buck stage and feedback amplifiers facing the controller
`timescale 1ns/1ps
`default_nettype none

module bcpi_buck_model (
	input  wire logic        mclk,
	input  wire logic        pwm_out,
	input  wire logic        ovr,
	input  wire logic [11:0] ovr_vout,
	input  wire logic [11:0] ovr_isense,
	input  wire logic [11:0] ovr_vbatt,
	input  wire logic [11:0] ovr_temp,
	output logic      [11:0] vout_meas,
	output logic      [11:0] isense_meas,
	output logic      [11:0] vbatt_meas,
	output logic      [11:0] temp_meas
);
	logic [11:0] vout_q = 12'h000;

	// crude lc filter: output climbs while switched on, sags while off
	always @(posedge mclk) begin
		if (pwm_out === 1'b1 && vout_q != 12'hFFF)
			vout_q <= vout_q + 12'h001;
		else if (pwm_out !== 1'b1 && vout_q != 12'h000)
			vout_q <= vout_q - 12'h001;
	end

	// the bench may pin the samples to force exact error terms
	assign vout_meas   = ovr ? ovr_vout : vout_q;
	assign isense_meas = ovr ? ovr_isense : vout_q >> 3;
	assign vbatt_meas  = ovr ? ovr_vbatt : vout_q >> 1;
	assign temp_meas   = ovr ? ovr_temp : 12'h100;
endmodule // bcpi_buck_model

`default_nettype wire

// ==== sim/tb_top.sv ====
// self-checking bench of the charger controller
`timescale 1ns/1ps
`default_nettype none

module tb_top;
	typedef struct {
		logic cc; logic fast; logic [11:0] mv; logic [11:0] mi;
		logic [15:0] exp;
	} bcpi_row_t;
	logic mclk, rst, charge_enable, mode_cc, velocity_form, fast_charge;
	logic temp_sense_present, ovr, pwm_out, charging, charge_done;
	logic safety_fault, current_limited;
	logic [11:0] voltage_setpoint, current_setpoint, rated_capacity;
	logic [11:0] current_limit, term_voltage, vout_limit, vbatt_limit;
	logic [11:0] temp_limit, vout_meas, isense_meas, vbatt_meas, temp_meas;
	logic [11:0] ov, oi, ob, ot;
	logic signed [7:0] proportional_gain, integral_gain;
	logic [15:0] duty;
	int num_errors = 0;
	int checks_done = 0;
	int n;
	bcpi_row_t rows[6];

	bcpi_ctrl #(.TICK_CYCLES(20), .PWM_PERIOD(10), .MEAS_W(12)) dut (
		.mclk, .rst, .charge_enable, .mode_cc, .velocity_form, .fast_charge,
		.temp_sense_present, .voltage_setpoint, .current_setpoint,
		.rated_capacity, .current_limit, .term_voltage, .vout_limit,
		.vbatt_limit, .temp_limit, .proportional_gain, .integral_gain,
		.vout_meas, .isense_meas, .vbatt_meas, .temp_meas, .pwm_out, .duty,
		.charging, .charge_done, .safety_fault, .current_limited);

	bcpi_buck_model partner (.mclk, .pwm_out, .ovr, .ovr_vout(ov),
		.ovr_isense(oi), .ovr_vbatt(ob), .ovr_temp(ot), .vout_meas,
		.isense_meas, .vbatt_meas, .temp_meas);

	initial begin
		mclk = 1'b0;
		forever #20 mclk = ~mclk;
	end

	task automatic cyc(input int c);
		repeat (c) @(negedge mclk);
	endtask

	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		checks_done++;
		if (seen !== exp) begin
			num_errors++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	// leave charge so pi state clears, then request it again
	task automatic restart();
		charge_enable = 1'b0;
		cyc(2);
		charge_enable = 1'b1;
	endtask

	task automatic wait_duty(input logic [15:0] v);
		for (int i = 0; i < 100 && duty !== v; i++) cyc(1);
		check(duty, v);
	endtask

	// count drive cycles over two switching periods
	task automatic count_hi();
		n = 0;
		repeat (20) begin
			cyc(1);
			n += (pwm_out === 1'b1);
		end
	endtask

	task automatic summarize();
		$display("errors %0d checks %0d", num_errors, checks_done);
		if (num_errors == 0 && checks_done > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	// hang guard, about three times the expected run
	initial begin
		#160000;
		num_errors++;
		summarize();
	end

	initial begin
		rst = 1'b1; charge_enable = 1'b0; mode_cc = 1'b0; fast_charge = 1'b0;
		velocity_form = 1'b0; temp_sense_present = 1'b1; ovr = 1'b1;
		voltage_setpoint = 12'h064; current_setpoint = 12'h01E;
		rated_capacity = 12'h028; current_limit = 12'h032;
		term_voltage = 12'h320; vout_limit = 12'h7D0;
		vbatt_limit = 12'h3E8; temp_limit = 12'h12C;
		proportional_gain = 8'sh10; integral_gain = 8'sh00;
		ov = 12'h05F; oi = 12'h00A; ob = 12'h000; ot = 12'h000;
		rows[0] = '{1'b0, 1'b0, 12'h05F, 12'h00A, 16'h0005};
		rows[1] = '{1'b0, 1'b0, 12'h028, 12'h00A, 16'h000A};
		rows[2] = '{1'b0, 1'b0, 12'h078, 12'h00A, 16'h0000};
		rows[3] = '{1'b1, 1'b0, 12'h1F4, 12'h018, 16'h0006};
		rows[4] = '{1'b1, 1'b1, 12'h1F4, 12'h021, 16'h0007};
		rows[5] = '{1'b1, 1'b0, 12'h1F4, 12'h028, 16'h0000};
		cyc(2);
		rst = 1'b0;
		check(duty, 16'h0000);
		check({pwm_out, charging}, 2'b00);
		// proportional law per mode, with saturation and fixed period
		foreach (rows[r]) begin
			mode_cc = rows[r].cc; fast_charge = rows[r].fast;
			ov = rows[r].mv; oi = rows[r].mi;
			restart();
			cyc(45);
			check(duty, rows[r].exp);
			count_hi();
			check(n[15:0], {rows[r].exp[14:0], 1'b0});
		end
		mode_cc = 1'b0; fast_charge = 1'b0; oi = 12'h00A;
		proportional_gain = 8'sh00; integral_gain = 8'sh10; ov = 12'h061;
		restart();
		wait_duty(16'h0003);
		cyc(19);
		check(duty, 16'h0003);
		cyc(3);
		check(duty, 16'h0006);
		velocity_form = 1'b1; proportional_gain = 8'sh10; ov = 12'h062;
		restart();
		wait_duty(16'h0002);
		cyc(22);
		check(duty, 16'h0006);
		velocity_form = 1'b0; integral_gain = 8'sh00; ov = 12'h05F;
		restart();
		cyc(45);
		oi = 12'h03C;
		cyc(3);
		check(current_limited, 1'b1);
		count_hi();
		check(n[15:0], 16'h0000);
		check(duty, 16'h0005);
		mode_cc = 1'b1;
		cyc(3);
		check(current_limited, 1'b0);
		mode_cc = 1'b0; oi = 12'h00A;
		restart();
		cyc(5);
		ob = 12'h320;
		cyc(3);
		check({charge_done, charging, pwm_out}, 3'b100);
		ob = 12'h000;
		cyc(3);
		check(charge_done, 1'b1);
		// each safety trip; battery trip also meets termination
		for (int t = 0; t < 3; t++) begin
			restart();
			cyc(45);
			if (t == 0) ov = 12'h7D1;
			if (t == 1) ob = 12'h3E9;
			if (t == 2) ot = 12'h12D;
			cyc(3);
			check({safety_fault, charge_done, pwm_out}, 3'b100);
			ov = 12'h05F; ob = 12'h000; ot = 12'h000;
		end
		restart();
		cyc(45);
		rst = 1'b1;
		cyc(2);
		check(duty, 16'h0000);
		check(pwm_out, 1'b0);
		rst = 1'b0; ovr = 1'b0;
		// closed loop against the converter model
		restart();
		cyc(600);
		check(charging, 1'b1);
		check(duty <= 16'h000A, 1'b1);
		summarize();
	end
endmodule // tb_top

`default_nettype wire
